// ===== bench/pp_transfer_extended_arith_unit_decode_tb.sv
// self-checking bench for the transfer-decode and extended-ALU block
`timescale 1ns/1ns
module pp_transfer_extended_arith_unit_decode_tb import ppd_pkg::*; ;
	typedef struct packed {
		logic [3:0] m;
		logic [1:0] le;
		logic [1:0] sz;
		logic [1:0] rm;
		logic [3:0] fmt;
		logic acc;
		logic wb;
	} ppd_row_t;
	logic core_clk, rst_n, instr_valid, carry_in, out_valid, extended_arith_unit_carry;
	logic [63:0] instr;
	logic [3:0] pp_fmt;
	ppd_flags_t flags;
	logic [31:0] extended_op_select_reg, alu_a, alu_b, alu_c, extended_arith_unit_result;
	logic [ADDR_W-1:0] local_ptr, local_idx, local_imm, global_ptr, global_idx, global_imm, dba_base, pba_base;
	ppd_xfer_t local_xfer, global_xfer;
	ppd_gate_t gate;
	int fail_count = 0;
	int checks_done = 0;
	// mode, load/ext, size, rel, format, access, write-back
	ppd_row_t rows [20] = '{16'h0A04, 16'h4A07, 16'h5C07, 16'h6107, 16'h7A87, 16'h8AC6, 16'h9A06, 16'hAA06,
		16'hBA86, 16'hCA07, 16'hDA1B, 16'hEAC7, 16'hFA07, 16'hE605, 16'h4B04, 16'hCA44, 16'hCA0C, 16'hC90F,
		16'hCA14, 16'hD813};
	// function codes built as and-term xor add-term
	logic [7:0] efn [7] = '{FN_PASS_C, 8'hFF, 8'hAA ^ 8'hCC, 8'h00 ^ 8'h3C, 8'h28 ^ 8'h00, 8'h00 ^ 8'hC3, 8'h96};
	logic [2:0] emd [7] = '{3'h0, 3'h2, 3'h5, 3'h1, 3'h1, 3'h1, 3'h4};

	ppd_decode i_dut (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
		.pp_fmt(pp_fmt), .flags(flags), .local_ptr(local_ptr), .local_idx(local_idx), .local_imm(local_imm),
		.global_ptr(global_ptr), .global_idx(global_idx), .global_imm(global_imm), .dba_base(dba_base),
		.pba_base(pba_base), .extended_op_select_reg(extended_op_select_reg), .alu_a(alu_a), .alu_b(alu_b),
		.alu_c(alu_c), .carry_in(carry_in), .out_valid(out_valid), .local_xfer(local_xfer),
		.global_xfer(global_xfer), .gate(gate), .extended_arith_unit_result(extended_arith_unit_result), .extended_arith_unit_carry(extended_arith_unit_carry));
	ppd_agent i_agent (.core_clk(core_clk), .rst_n(rst_n), .out_valid(out_valid), .local_xfer(local_xfer),
		.global_xfer(global_xfer), .local_ptr(local_ptr), .local_idx(local_idx), .local_imm(local_imm),
		.global_ptr(global_ptr), .global_idx(global_idx), .global_imm(global_imm), .dba_base(dba_base),
		.pba_base(pba_base));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [63:0] mk(logic g, logic [3:0] m, logic [1:0] le, logic [1:0] sz, logic [1:0] rm);
		logic [63:0] w;
		w = '0;
		w[(g ? GMODE_LSB : LMODE_LSB)+:MODE_W] = m;
		w[g ? GLS_BIT : LLS_BIT] = le[1];
		w[g ? GEXT_BIT : LEXT_BIT] = le[0];
		w[(g ? GSIZE_LSB : LSIZE_LSB)+:2] = sz;
		w[(g ? GRM_LSB : LRM_LSB)+:2] = rm;
		return w;
	endfunction

	// upper half is the access address, lower half the pointer after the operation
	function automatic logic [63:0] xa(logic [3:0] m, logic [31:0] p, x, i, logic [1:0] rm);
		logic [31:0] off, calc, base;
		off = m[MODE_IMM_BIT] ? i : x;
		calc = m[MODE_SUB_BIT] ? p - off : p + off;
		base = (rm == RM_DBA) ? dba_base : (rm == RM_PBA) ? pba_base : 32'h0000_0000;
		return {((m[3:2] == 2'h1) ? p : calc) + base, (m[3:2] == 2'h2) ? p : calc};
	endfunction

	function automatic logic cexp(logic [3:0] cc, ppd_flags_t f);
		logic [3:0] sel;
		sel = {f.n, f.v, f.z, f.c};
		case (cc)
			4'h0: return 1'b1;
			4'h1: return ~f.n & ~f.z;
			4'h2: return ~f.c | f.z;
			4'h3: return f.c & ~f.z;
			4'h4: return f.n ^ f.v;
			4'h5: return (f.n ^ f.v) | f.z;
			4'h6: return ~(f.n ^ f.v);
			4'h7: return ~(f.n ^ f.v) & ~f.z;
			default: return sel[cc[2:1]] ^ cc[0];
		endcase
	endfunction

	// expected result per function row, written from the function's meaning; c is all zeros or all ones
	function automatic logic [32:0] eexp(int s, logic [31:0] a, b, c, logic ci);
		logic [31:0] pick;
		pick = b ^ c;
		case (s)
			0: return {1'b0, c};
			1: return {1'b0, 32'hFFFF_FFFF} + 33'h1;
			2: return {1'b0, a} + {1'b0, b} + {32'h0, ci};
			3: return {1'b0, pick};
			4: return {1'b0, a & pick};
			5: return {1'b0, ~pick};
			default: return {1'b0, a ^ b ^ c} + {32'h0, ci};
		endcase
	endfunction

	task automatic gtry(input logic [3:0] f, input logic [3:0] cc, input logic [3:0] fl, input logic ea);
		logic [63:0] w, ex;
		w = mk(1'b1, 4'hC, 2'h3, SZ_HALF, RM_DBA);
		w[COND_LSB+:COND_W] = cc;
		w[QUAL_GLB_BIT] = 1'b1;
		instr = w;
		pp_fmt = f;
		flags = fl;
		ex = xa(4'hC, global_ptr, global_idx, global_imm, RM_DBA);
		@(negedge core_clk);
		chk("g_access", global_xfer.access, ea);
		chk("g_wb", global_xfer.wb, ea);
		chk("l_access", local_xfer.access, 1'b0);
		if (ea) begin
			chk("g_ld_sext", {global_xfer.ld, global_xfer.sext}, 2'h3);
			chk("g_size", global_xfer.size, SZ_HALF);
			chk("g_addr", global_xfer.addr, ex[63:32]);
			chk("g_ptr", global_xfer.new_ptr, ex[31:0]);
		end
	endtask

	initial begin
		ppd_row_t r;
		logic [63:0] ex, w;
		logic [32:0] ee;
		logic [2:0] q;
		logic c;
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		pp_fmt = FMT_1;
		flags = '0;
		carry_in = 1'b0;
		extended_op_select_reg = '0;
		alu_a = '0;
		alu_b = '0;
		alu_c = '0;
		repeat (4) @(negedge core_clk);
		chk("rst_valid", out_valid, 1'b0);
		rst_n = 1'b1;
		@(negedge core_clk);
		chk("rel_xfer", local_xfer.access, 1'b0);
		instr_valid = 1'b1;
		for (int k = 0; k < 20; k++) begin
			r = rows[k];
			instr = mk(1'b0, r.m, r.le, r.sz, r.rm);
			pp_fmt = r.fmt;
			ex = xa(r.m, local_ptr, local_idx, local_imm, r.rm);
			@(negedge core_clk);
			chk("out_valid", out_valid, 1'b1);
			chk("l_access", local_xfer.access, r.acc);
			chk("l_wb", local_xfer.wb, r.wb);
			chk("g_access", global_xfer.access, 1'b0);
			chk("gate", gate, 3'h7);
			chk("l_arith", local_xfer.arith, r.le == 2'h1);
			if (r.acc) begin
				chk("l_ld_sext", {local_xfer.ld, local_xfer.sext}, r.le);
				chk("l_size", local_xfer.size, r.sz);
				chk("l_addr", local_xfer.addr, ex[63:32]);
			end
			if (r.wb) chk("l_ptr", local_xfer.new_ptr, ex[31:0]);
		end
		gtry(FMT_5, CC_Z, 4'h0, 1'b1);
		gtry(FMT_9, CC_Z, 4'h0, 1'b0);
		gtry(FMT_9, CC_Z, 4'h4, 1'b1);
		gtry(FMT_2, CC_U, 4'h0, 1'b0);
		gtry(FMT_1, CC_U, 4'h0, 1'b1);
		// global address arithmetic: pointer moves, memory is left alone
		instr = mk(1'b1, 4'hC, 2'h1, SZ_WORD, RM_ABS);
		pp_fmt = FMT_5;
		ex = xa(4'hC, global_ptr, global_idx, global_imm, RM_ABS);
		@(negedge core_clk);
		chk("g_arith", {global_xfer.access, global_xfer.wb, global_xfer.arith}, 3'h3);
		chk("g_arith_ptr", global_xfer.new_ptr, ex[31:0]);
		// every code against every flag pattern, once in one of the four conditional formats (chosen by flag bits 1-0) and once in the immediate one
		for (int i = 0; i < 512; i++) begin
			q = i[2:0] ^ i[6:4];
			w = '0;
			w[COND_LSB+:COND_W] = i[7:4];
			w[QUAL_SRC_BIT+:3] = q;
			instr = w;
			flags = i[3:0];
			pp_fmt = i[8] ? FMT_DIMM : FMT_COND_LO + {2'h0, i[1:0]};
			c = cexp(i[7:4], i[3:0]);
			@(negedge core_clk);
			if (i[8]) chk("gate_imm", gate, {1'b1, c, 1'b1});
			else chk("gate_cond", gate, {q[0] ? c : 1'b1, q[1] ? c : 1'b1, q[2] ? c : 1'b1});
		end
		for (int k = 0; k < 14; k++) begin
			extended_op_select_reg = {2'h0, emd[k/2], efn[k/2], 19'h0};
			alu_a = 32'h89AB_CDEF + k;
			alu_b = 32'h1357_9BDF;
			alu_c = k[0] ? 32'hFFFF_FFFF : 32'h0000_0000;
			carry_in = ~k[0];
			ee = eexp(k / 2, alu_a, alu_b, alu_c, carry_in);
			@(negedge core_clk);
			chk("extended_arith_unit", extended_arith_unit_result, ee[31:0]);
			chk("extended_arith_unit_c", extended_arith_unit_carry, ee[32]);
		end
		instr = mk(1'b0, 4'hC, 2'h2, SZ_WORD, RM_ABS);
		pp_fmt = FMT_1;
		instr_valid = 1'b0;
		@(negedge core_clk);
		chk("idle_acc", {out_valid, local_xfer.access, gate}, 5'h00);
		instr_valid = 1'b1;
		rst_n = 1'b0;
		@(negedge core_clk);
		chk("mid_rst", out_valid, 1'b0);
		instr_valid = 1'b0;
		rst_n = 1'b1;
		@(negedge core_clk);
		chk("mid_rel", {out_valid, local_xfer.access}, 2'h0);
		close_out();
	end

	// about five times the planned run length
	initial begin
		repeat (3000) @(posedge core_clk);
		fail_count++;
		close_out();
	end
endmodule // pp_transfer_extended_arith_unit_decode_tb

// ===== bench/ppd_agent.sv
// address-unit side model: per-unit pointer, index and immediate, RAM base values
`timescale 1ns/1ns
module ppd_agent import ppd_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic out_valid,
	input wire ppd_xfer_t local_xfer,
	input wire ppd_xfer_t global_xfer,
	output logic [ADDR_W-1:0] local_ptr,
	output logic [ADDR_W-1:0] local_idx,
	output logic [ADDR_W-1:0] local_imm,
	output logic [ADDR_W-1:0] global_ptr,
	output logic [ADDR_W-1:0] global_idx,
	output logic [ADDR_W-1:0] global_imm,
	output logic [ADDR_W-1:0] dba_base,
	output logic [ADDR_W-1:0] pba_base
);
	// distinct values per unit, so taking the other unit's index shows in the address
	assign local_idx = 32'h0000_0010;
	assign global_idx = 32'h0000_0220;
	assign local_imm = 32'h0000_0104;
	assign global_imm = 32'h0000_0048;
	assign dba_base = 32'h0100_0000;
	assign pba_base = 32'h0101_0000;
	// pointer writes land one edge after the decode; no forwarding to a back-to-back use
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			local_ptr <= 32'h0000_8000;
		end else if (out_valid && local_xfer.wb) begin
			local_ptr <= local_xfer.new_ptr;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			global_ptr <= 32'h0004_0000;
		end else if (out_valid && global_xfer.wb) begin
			global_ptr <= global_xfer.new_ptr;
		end
	end
endmodule // ppd_agent

// ===== logic/ppd_decode.sv
// parallel-transfer addressing, condition and extended-ALU decoder
// Operation
// - local mode from bits 35-38, global mode from bits 13-16 where carried
// - mode 00xx no address op; 01xx access at pointer then update pointer
// - mode 10xx access at pointer plus/minus offset, pointer unchanged
// - mode 11xx access at pointer plus/minus offset, result written to pointer
// - index register comes from the same unit as the pointer
// - local load/store select bit 21, extension select bit 31
// - global load/store select bit 17, extension select bit 9
// - 10 zero load, 11 sign load, 00 store, 01 address arithmetic
// - size 00 byte, 01 halfword, 10 word, 11 reserved
// - field-move format 3 accepts only byte and halfword
// - relative field 00 absolute, 01 reserved, 10 data RAM base, 11 parameter base
// - formats 7-10 gate source, result, global by their own qualifier bits
// - 32-bit-immediate format gates only the result write
// - condition bits 35-32; u, positive, lower-or-same, higher
// - signed codes lt, le, ge, gt from N, V and Z
// - codes 8-F give C, ~C, Z, ~Z, V, ~V, N, ~N
// - extended ALU operation comes from the extended-op register at execution
// - boolean mode bits 19-26 enable the eight minterms of A, B, C
// - optional add of one or carry-in to the result
// - arithmetic mode A AND f1(B,C) plus f2(B,C), code is (A AND f1) xor f2
// - select codes 28/3C and 82/C3 choose B or its complement by C
`timescale 1ns/1ns
module ppd_decode import ppd_pkg::*; #(
	parameter int DW = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [63:0] instr,
	input wire logic [3:0] pp_fmt,
	input wire ppd_flags_t flags,
	input wire logic [ADDR_W-1:0] local_ptr,
	input wire logic [ADDR_W-1:0] local_idx,
	input wire logic [ADDR_W-1:0] local_imm,
	input wire logic [ADDR_W-1:0] global_ptr,
	input wire logic [ADDR_W-1:0] global_idx,
	input wire logic [ADDR_W-1:0] global_imm,
	input wire logic [ADDR_W-1:0] dba_base,
	input wire logic [ADDR_W-1:0] pba_base,
	input wire logic [31:0] extended_op_select_reg,
	input wire logic [DW-1:0] alu_a,
	input wire logic [DW-1:0] alu_b,
	input wire logic [DW-1:0] alu_c,
	input wire logic carry_in,
	output logic out_valid,
	output ppd_xfer_t local_xfer,
	output ppd_xfer_t global_xfer,
	output ppd_gate_t gate,
	output logic [DW-1:0] extended_arith_unit_result,
	output logic extended_arith_unit_carry
);

	function automatic ppd_xfer_t au_decode(
		input logic [MODE_W-1:0] mode,
		input logic ls,
		input logic ext,
		input logic [1:0] sz,
		input logic [1:0] rm,
		input logic fmove,
		input logic [ADDR_W-1:0] ptr,
		input logic [ADDR_W-1:0] idx,
		input logic [ADDR_W-1:0] imm,
		input logic [ADDR_W-1:0] bd,
		input logic [ADDR_W-1:0] bp
	);
		ppd_xfer_t x;
		logic [ADDR_W-1:0] off;
		logic [ADDR_W-1:0] calc;
		logic [ADDR_W-1:0] base;
		logic bad;
		logic act;
		x = '0;
		// caller passes the index of the pointer's own unit
		off = mode[MODE_IMM_BIT] ? imm : idx;
		calc = mode[MODE_SUB_BIT] ? ptr - off : ptr + off;
		case (rm)
			RM_DBA: base = bd;
			RM_PBA: base = bp;
			default: base = '0;
		endcase
		bad = (sz == SZ_RSV) || (rm == RM_RSV);
		if (fmove && sz == SZ_WORD) begin
			bad = 1'b1;
		end
		x.ld = ls;
		x.sext = ls & ext;
		x.arith = ~ls & ext;
		x.size = sz;
		case (mode[3:2])
			MODE_POST: begin
				x.addr = ptr;
				x.new_ptr = calc;
				x.wb = 1'b1;
			end
			MODE_PRE: begin
				x.addr = calc;
				x.new_ptr = ptr;
			end
			MODE_PREWB: begin
				x.addr = calc;
				x.new_ptr = calc;
				x.wb = 1'b1;
			end
			default: begin
				x.new_ptr = ptr;
			end
		endcase
		act = (mode[3:2] != MODE_NOP) && !bad;
		// base is applied to the access only; the pointer keeps its unit-relative value
		x.addr = act ? x.addr + base : '0;
		x.access = act && !x.arith;
		x.wb = x.wb && act;
		return x;
	endfunction

	function automatic logic cond_eval(input logic [COND_W-1:0] cc, input ppd_flags_t f);
		logic r;
		r = 1'b1;
		case (cc)
			CC_U: r = 1'b1;
			CC_P: r = ~f.n & ~f.z;
			CC_LS: r = ~f.c | f.z;
			CC_HI: r = f.c & ~f.z;
			CC_LT: r = f.n ^ f.v;
			CC_LE: r = (f.n ^ f.v) | f.z;
			CC_GE: r = ~(f.n ^ f.v);
			CC_GT: r = ~(f.n ^ f.v) & ~f.z;
			CC_C: r = f.c;
			CC_NC: r = ~f.c;
			CC_Z: r = f.z;
			CC_NZ: r = ~f.z;
			CC_V: r = f.v;
			CC_NV: r = ~f.v;
			CC_N: r = f.n;
			CC_NN: r = ~f.n;
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	logic [MODE_W-1:0] lmode;
	logic [MODE_W-1:0] gmode;
	logic has_local;
	logic has_global;
	logic cond_fmt;
	logic cond_ok;
	ppd_xfer_t next_local;
	ppd_xfer_t next_global;
	ppd_gate_t next_gate;

	assign lmode = instr[LMODE_LSB +: MODE_W];
	assign gmode = instr[GMODE_LSB +: MODE_W];
	assign has_local = pp_fmt inside {FMT_1, FMT_2, FMT_FIELD, FMT_4, FMT_6};
	assign has_global = pp_fmt inside {FMT_1, FMT_5, FMT_9};
	assign cond_fmt = (pp_fmt >= FMT_COND_LO) && (pp_fmt <= FMT_COND_HI);
	assign cond_ok = cond_eval(instr[COND_LSB +: COND_W], flags);

	always_comb begin
		next_local = au_decode(lmode, instr[LLS_BIT], instr[LEXT_BIT],
			instr[LSIZE_LSB +: 2], instr[LRM_LSB +: 2], pp_fmt == FMT_FIELD,
			local_ptr, local_idx, local_imm, dba_base, pba_base);
		next_global = au_decode(gmode, instr[GLS_BIT], instr[GEXT_BIT],
			instr[GSIZE_LSB +: 2], instr[GRM_LSB +: 2], 1'b0,
			global_ptr, global_idx, global_imm, dba_base, pba_base);
		next_gate = '{src: 1'b1, res: 1'b1, glob: 1'b1};
		if (cond_fmt) begin
			next_gate.src = !instr[QUAL_SRC_BIT] || cond_ok;
			next_gate.res = !instr[QUAL_RES_BIT] || cond_ok;
			next_gate.glob = !instr[QUAL_GLB_BIT] || cond_ok;
		end else if (pp_fmt == FMT_DIMM) begin
			next_gate.res = cond_ok;
		end
		if (!has_local || !instr_valid) begin
			next_local.access = 1'b0;
			next_local.wb = 1'b0;
		end
		// a failed global condition cancels both the access and the pointer update
		if (!has_global || !instr_valid || !next_gate.glob) begin
			next_global.access = 1'b0;
			next_global.wb = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			local_xfer <= '0;
			global_xfer <= '0;
			gate <= '0;
		end else begin
			out_valid <= instr_valid;
			local_xfer <= next_local;
			global_xfer <= next_global;
			gate <= instr_valid ? next_gate : '0;
		end
	end

	// extended ALU: the opcode only brings operands, the register names the operation
	logic [FUNC_W-1:0] func_code;
	logic arith_mode;
	logic [DW-1:0] bool_v;
	logic [DW-1:0] f1_v;
	logic [DW-1:0] f2_v;
	logic [DW:0] next_sum;
	logic inc;

	assign func_code = extended_op_select_reg[FUNC_LSB +: FUNC_W];
	assign arith_mode = extended_op_select_reg[EOP_ARITH_BIT];
	assign inc = extended_op_select_reg[EOP_ADD1_BIT] ||
		(extended_op_select_reg[EOP_CIN_BIT] && carry_in);

	// minterm index is {C,B,A}; f2 is independent of A so it sits in the A=0 entries
	genvar i;
	generate
		for (i = 0; i < DW; i++) begin : g_bit
			assign bool_v[i] = func_code[{alu_c[i], alu_b[i], alu_a[i]}];
			assign f2_v[i] = func_code[{alu_c[i], alu_b[i], 1'b0}];
			assign f1_v[i] = func_code[{alu_c[i], alu_b[i], 1'b1}] ^ f2_v[i];
		end
	endgenerate

	always_comb begin
		if (arith_mode) begin
			next_sum = {1'b0, alu_a & f1_v} + {1'b0, f2_v} + {{DW{1'b0}}, inc};
		end else begin
			next_sum = {1'b0, bool_v} + {{DW{1'b0}}, inc};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			extended_arith_unit_result <= '0;
			extended_arith_unit_carry <= 1'b0;
		end else begin
			extended_arith_unit_result <= next_sum[DW-1:0];
			extended_arith_unit_carry <= next_sum[DW];
		end
	end

	property p_nop_mode;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(lmode[3:2] == MODE_NOP) |-> !local_xfer.access && !local_xfer.wb;
	endproperty
	a_nop_mode: assert property (p_nop_mode) else $error("no-op mode produced a transfer");

	property p_post_addr;
		@(posedge core_clk) disable iff (!rst_n)
		local_xfer.access && $past(lmode[3:2] == MODE_POST && instr[LRM_LSB +: 2] == RM_ABS)
		|-> local_xfer.addr == $past(local_ptr) && local_xfer.wb;
	endproperty
	a_post_addr: assert property (p_post_addr) else $error("post mode address wrong");

	property p_pre_nowb;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(lmode[3:2] == MODE_PRE) |-> !local_xfer.wb;
	endproperty
	a_pre_nowb: assert property (p_pre_nowb) else $error("pre mode wrote pointer");

	property p_prewb;
		@(posedge core_clk) disable iff (!rst_n)
		local_xfer.access && $past(lmode[3:2] == MODE_PREWB && instr[LRM_LSB +: 2] == RM_ABS)
		|-> local_xfer.addr == local_xfer.new_ptr && local_xfer.wb;
	endproperty
	a_prewb: assert property (p_prewb) else $error("pre-modify address differs from pointer");

	property p_global_index;
		@(posedge core_clk) disable iff (!rst_n)
		global_xfer.wb && $past(gmode == {MODE_PREWB, 2'b00})
		|-> global_xfer.new_ptr == ADDR_W'($past(global_ptr) + $past(global_idx));
	endproperty
	a_global_index: assert property (p_global_index) else $error("global index not from global unit");

	property p_local_type;
		@(posedge core_clk) disable iff (!rst_n)
		local_xfer.access |-> local_xfer.ld == $past(instr[LLS_BIT])
			&& local_xfer.sext == ($past(instr[LLS_BIT]) && $past(instr[LEXT_BIT]));
	endproperty
	a_local_type: assert property (p_local_type) else $error("local transfer type wrong");

	property p_global_arith;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(!instr[GLS_BIT] && instr[GEXT_BIT]) |-> !global_xfer.access;
	endproperty
	a_global_arith: assert property (p_global_arith) else $error("address arithmetic accessed memory");

	property p_reserved;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(instr[LSIZE_LSB +: 2] == SZ_RSV || instr[LRM_LSB +: 2] == RM_RSV)
		|-> !local_xfer.access && !local_xfer.wb;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code made a transfer");

	property p_field_word;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(pp_fmt == FMT_FIELD && instr[LSIZE_LSB +: 2] == SZ_WORD) |-> !local_xfer.access;
	endproperty
	a_field_word: assert property (p_field_word) else $error("field move accepted word size");

	property p_dimm_gate;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(pp_fmt == FMT_DIMM) |-> gate.src && gate.glob
			&& gate.res == $past(cond_ok);
	endproperty
	a_dimm_gate: assert property (p_dimm_gate) else $error("immediate format gated wrong term");

	property p_always;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(cond_fmt && instr[COND_LSB +: COND_W] == CC_U) |-> gate.src && gate.res && gate.glob;
	endproperty
	a_always: assert property (p_always) else $error("unconditional code blocked");

	property p_bool_pass;
		@(posedge core_clk) disable iff (!rst_n)
		!arith_mode && func_code == FN_PASS_C && !inc |=> extended_arith_unit_result == $past(alu_c);
	endproperty
	a_bool_pass: assert property (p_bool_pass) else $error("boolean minterm select wrong");

	property p_arith_add;
		@(posedge core_clk) disable iff (!rst_n)
		arith_mode && func_code == FN_A_PLUS_B && !inc |=> extended_arith_unit_result == DW'($past(alu_a) + $past(alu_b));
	endproperty
	a_arith_add: assert property (p_arith_add) else $error("arithmetic A plus B wrong");

	// the base is added to the access address only, never to the pointer
	property p_post_base;
		@(posedge core_clk) disable iff (!rst_n)
		local_xfer.access && $past(lmode[3:2] == MODE_POST && instr[LRM_LSB +: 2] == RM_DBA)
		|-> local_xfer.addr == ADDR_W'($past(local_ptr) + $past(dba_base));
	endproperty
	a_post_base: assert property (p_post_base) else $error("data RAM base not applied");

	property p_global_gate;
		@(posedge core_clk) disable iff (!rst_n)
		out_valid && $past(cond_fmt && instr[QUAL_GLB_BIT] && !cond_ok) |-> !global_xfer.access && !global_xfer.wb;
	endproperty
	a_global_gate: assert property (p_global_gate) else $error("failed condition passed global transfer");

	c_post: cover property (@(posedge core_clk) disable iff (!rst_n) local_xfer.access && local_xfer.wb);
	c_cond_block: cover property (@(posedge core_clk) disable iff (!rst_n) out_valid && !gate.glob);
	c_arith_carry: cover property (@(posedge core_clk) disable iff (!rst_n) extended_arith_unit_carry);
	c_global_arith: cover property (@(posedge core_clk) disable iff (!rst_n) global_xfer.wb && global_xfer.arith);

endmodule // ppd_decode

// ===== logic/ppd_pkg.sv
// constants and carrier types for the parallel-transfer and extended-ALU decoder
package ppd_pkg;
	localparam int ADDR_W = 32;
	localparam int MODE_W = 4;
	localparam int LMODE_LSB = 35;
	localparam int GMODE_LSB = 13;
	localparam int LLS_BIT = 21;
	localparam int LEXT_BIT = 31;
	localparam int GLS_BIT = 17;
	localparam int GEXT_BIT = 9;
	localparam int LSIZE_LSB = 39;
	localparam int GSIZE_LSB = 7;
	localparam int LRM_LSB = 41;
	localparam int GRM_LSB = 11;
	localparam int COND_LSB = 32;
	localparam int COND_W = 4;
	localparam int QUAL_SRC_BIT = 43;
	localparam int QUAL_RES_BIT = 44;
	localparam int QUAL_GLB_BIT = 45;
	localparam int FUNC_LSB = 19;
	localparam int FUNC_W = 8;
	localparam int EOP_ARITH_BIT = 27;
	localparam int EOP_ADD1_BIT = 28;
	localparam int EOP_CIN_BIT = 29;
	localparam int MODE_IMM_BIT = 1;
	localparam int MODE_SUB_BIT = 0;
	localparam logic [1:0] MODE_NOP = 2'h0;
	localparam logic [1:0] MODE_POST = 2'h1;
	localparam logic [1:0] MODE_PRE = 2'h2;
	localparam logic [1:0] MODE_PREWB = 2'h3;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_RSV = 2'h3;
	localparam logic [1:0] RM_ABS = 2'h0;
	localparam logic [1:0] RM_RSV = 2'h1;
	localparam logic [1:0] RM_DBA = 2'h2;
	localparam logic [1:0] RM_PBA = 2'h3;
	localparam logic [3:0] FMT_1 = 4'h1;
	localparam logic [3:0] FMT_2 = 4'h2;
	localparam logic [3:0] FMT_FIELD = 4'h3;
	localparam logic [3:0] FMT_4 = 4'h4;
	localparam logic [3:0] FMT_5 = 4'h5;
	localparam logic [3:0] FMT_6 = 4'h6;
	localparam logic [3:0] FMT_COND_LO = 4'h7;
	localparam logic [3:0] FMT_9 = 4'h9;
	localparam logic [3:0] FMT_COND_HI = 4'hA;
	localparam logic [3:0] FMT_DIMM = 4'hD;
	localparam logic [3:0] CC_U = 4'h0;
	localparam logic [3:0] CC_P = 4'h1;
	localparam logic [3:0] CC_LS = 4'h2;
	localparam logic [3:0] CC_HI = 4'h3;
	localparam logic [3:0] CC_LT = 4'h4;
	localparam logic [3:0] CC_LE = 4'h5;
	localparam logic [3:0] CC_GE = 4'h6;
	localparam logic [3:0] CC_GT = 4'h7;
	localparam logic [3:0] CC_C = 4'h8;
	localparam logic [3:0] CC_NC = 4'h9;
	localparam logic [3:0] CC_Z = 4'hA;
	localparam logic [3:0] CC_NZ = 4'hB;
	localparam logic [3:0] CC_V = 4'hC;
	localparam logic [3:0] CC_NV = 4'hD;
	localparam logic [3:0] CC_N = 4'hE;
	localparam logic [3:0] CC_NN = 4'hF;
	localparam logic [7:0] FN_PASS_C = 8'hF0;
	localparam logic [7:0] FN_A_PLUS_B = 8'h66;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} ppd_flags_t;

	typedef struct packed {
		logic access;
		logic wb;
		logic ld;
		logic sext;
		logic arith;
		logic [1:0] size;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] new_ptr;
	} ppd_xfer_t;

	typedef struct packed {
		logic src;
		logic res;
		logic glob;
	} ppd_gate_t;
endpackage
